// ---- rtl/tbpw_pkg.sv ----
// Package: register map, field layout and constants of the PWM unit
package tbpw_pkg;

  // ----------------------------------------------------------------
  // Register byte addresses (all chosen, one aligned word each)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_PWM_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_DUTY_LOW_BYTE = 8'h04;
  localparam logic [7:0] ADDR_DUTY_BUFFER_HIGH = 8'h08;
  localparam logic [7:0] ADDR_PERIOD_TIMER_COUNT = 8'h0C;
  localparam logic [7:0] ADDR_PERIOD_REG = 8'h10;
  localparam logic [7:0] ADDR_PERIOD_TIMER_CTRL = 8'h14;
  localparam logic [7:0] ADDR_FLAG_REG = 8'h18;
  localparam logic [7:0] ADDR_PIN_DIRECTION = 8'h1C;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTL_MODE_LSB = 0;      // unit_mode_bits 3:0
  localparam int CTL_DUTY_LSB = 4;      // duty_low_bits 5:4
  localparam int CTL_EMODE_LSB = 6;     // enhanced_mode_select 7:6
  localparam int TCTL_ON_BIT = 2;       // period_timer_on
  localparam int TCTL_PS_LSB = 0;       // prescale_select 1:0
  localparam int FLAG_OVF_BIT = 1;      // period_overflow_flag
  localparam int DIR_PRI_BIT = 0;       // primary pin direction
  localparam int DIR_SEC_BIT = 1;       // secondary pin direction

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_PWM_CONTROL = 8'h00;
  localparam logic [7:0] RST_TIMER_COUNT = 8'h00;
  localparam logic [7:0] RST_PERIOD_REG = 8'hFF;
  localparam logic [7:0] RST_TIMER_CTRL = 8'h00;
  localparam logic [1:0] RST_PIN_DIRECTION = 2'h3;
  localparam logic [7:0] RST_DUTY = 8'h00;

  // ----------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] EMODE_SINGLE = 2'h0;
  localparam logic [1:0] EMODE_HALF_BRIDGE = 2'h2;
  localparam logic [1:0] MODE_PWM_TOP = 2'h3;   // mode bits 3:2 = 11
  localparam int QUARTER_CYCLES = 4;            // system clocks per tick at 1:1 prescale

  // Prescale select: 00 -> 1, 01 -> 4, 1x -> 16
  typedef enum logic [1:0] {
    TBPW_PS_1 = 2'h0,
    TBPW_PS_4 = 2'h1,
    TBPW_PS_16 = 2'h2,
    TBPW_PS_16B = 2'h3
  } tbpw_ps_t;

  // APB request as one carrier
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } tbpw_apb_req_t;

  // Pin group: output value and active-low enables
  typedef struct packed {
    logic pri_out;
    logic pri_oe_n;
    logic sec_out;
    logic sec_oe_n;
  } tbpw_pins_t;

endpackage

// ---- rtl/tbpw_top.sv ----
// Timer-based PWM unit with APB register slave
`timescale 1ns/1ps
`default_nettype none

module tbpw_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sleep,
  output logic primary_output,
  output logic primary_oe_n,
  output logic secondary_output,
  output logic secondary_oe_n,
  output logic period_overflow_flag
);

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  tbpw_pkg::tbpw_apb_req_t req;  // Bundled request
  logic wr_en;                   // Write takes effect this edge
  logic addr_ok;                 // Address is mapped
  logic sleep_s1_q;              // Sleep synchroniser, first stage
  logic sleep_q;                 // Sleep, synchronised
  logic run;                     // Unit may advance this cycle

  assign req = '{psel: psel, penable: penable, pwrite: pwrite,
                 paddr: paddr, pwdata: pwdata};

  // Mapped addresses
  always_comb begin
    unique case (req.paddr)
      tbpw_pkg::ADDR_PWM_CONTROL,
      tbpw_pkg::ADDR_DUTY_LOW_BYTE,
      tbpw_pkg::ADDR_DUTY_BUFFER_HIGH,
      tbpw_pkg::ADDR_PERIOD_TIMER_COUNT,
      tbpw_pkg::ADDR_PERIOD_REG,
      tbpw_pkg::ADDR_PERIOD_TIMER_CTRL,
      tbpw_pkg::ADDR_FLAG_REG,
      tbpw_pkg::ADDR_PIN_DIRECTION: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end

  // Zero wait states; unmapped access answers with an error
  assign pready = 1'b1;
  assign pslverr = req.psel & req.penable & ~addr_ok;
  assign wr_en = req.psel & req.penable & req.pwrite & addr_ok;

  // Sleep arrives from outside the bus logic: two flops first
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sleep_s1_q <= 1'b0;
      sleep_q <= 1'b0;
    end else begin
      sleep_s1_q <= sleep;
      sleep_q <= sleep_s1_q;
    end
  end

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  logic [7:0] ctl_q;        // pwm_control
  logic [7:0] duty_byte_q;  // duty_low_byte
  logic [7:0] period_q;     // period_reg
  logic [7:0] tctl_q;       // period_timer_ctrl (bits 6:3 postscaler)
  logic [1:0] dir_q;        // Pin direction bits, 1 = input
  logic [3:0] mode_bits;    // unit_mode_bits
  logic [1:0] emode;        // enhanced_mode_select
  logic pwm_mode;           // Unit is in a PWM mode
  logic timer_on;           // period_timer_on

  assign mode_bits = ctl_q[tbpw_pkg::CTL_MODE_LSB +: 4];
  assign emode = ctl_q[tbpw_pkg::CTL_EMODE_LSB +: 2];
  assign pwm_mode = (mode_bits[3:2] == tbpw_pkg::MODE_PWM_TOP);
  assign timer_on = tctl_q[tbpw_pkg::TCTL_ON_BIT];
  // Sleep stalls every counter and latch; output flops hold
  assign run = ~sleep_q;

  // Control register; bit 6 of the enhanced field is kept as written
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_q <= tbpw_pkg::RST_PWM_CONTROL;
    end else if (wr_en && req.paddr == tbpw_pkg::ADDR_PWM_CONTROL) begin
      ctl_q <= req.pwdata[7:0];  // Duty bits any time
    end
  end

  // Duty byte, writable at any moment
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      duty_byte_q <= tbpw_pkg::RST_DUTY;
    end else if (wr_en && req.paddr == tbpw_pkg::ADDR_DUTY_LOW_BYTE) begin
      duty_byte_q <= req.pwdata[7:0];
    end
  end

  // Period register and timer control
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      period_q <= tbpw_pkg::RST_PERIOD_REG;
      tctl_q <= tbpw_pkg::RST_TIMER_CTRL;
    end else if (wr_en) begin
      if (req.paddr == tbpw_pkg::ADDR_PERIOD_REG) begin
        period_q <= req.pwdata[7:0];
      end
      if (req.paddr == tbpw_pkg::ADDR_PERIOD_TIMER_CTRL) begin
        tctl_q <= {1'b0, req.pwdata[6:0]};
      end
    end
  end

  // Pin direction: reset makes every pin an input
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dir_q <= tbpw_pkg::RST_PIN_DIRECTION;
    end else if (wr_en && req.paddr == tbpw_pkg::ADDR_PIN_DIRECTION) begin
      dir_q <= req.pwdata[1:0];  // Software clears to drive
    end
  end

  // ----------------------------------------------------------------
  // Prescaler and time base
  // ----------------------------------------------------------------
  logic [3:0] pre_q;         // Prescaler, counts system clocks
  logic [7:0] tmr_q;         // period_timer_count
  logic [3:0] pre_limit;     // Last prescaler count before a tick
  logic [1:0] sub_bits;      // Two low time-base bits
  logic [9:0] time_base;     // 10-bit time base
  logic tick;                // Period timer increments
  logic boundary;            // Period ends on this tick
  logic tmr_wr;              // Software writes the timer

  // Divide by 4*1, 4*4 or 4*16 system clocks per timer step
  always_comb begin
    unique case (tbpw_pkg::tbpw_ps_t'(tctl_q[tbpw_pkg::TCTL_PS_LSB +: 2]))
      tbpw_pkg::TBPW_PS_1: pre_limit = 4'h3;
      tbpw_pkg::TBPW_PS_4: pre_limit = 4'hF;
      tbpw_pkg::TBPW_PS_16,
      tbpw_pkg::TBPW_PS_16B: pre_limit = 4'hF;
    endcase
  end

  // Prescale 16 uses a wider chain; kept in a 6-bit form below
  logic [5:0] pre16_q;       // Prescaler for the 1:16 setting
  logic ps16;                // 1:16 selected
  assign ps16 = tctl_q[tbpw_pkg::TCTL_PS_LSB + 1];

  // Sub-bits: quarter-cycle count at 1:1, prescaler bits else
  always_comb begin
    if (ps16) begin
      sub_bits = pre16_q[5:4];
    end else if (tctl_q[tbpw_pkg::TCTL_PS_LSB]) begin
      sub_bits = pre_q[3:2];
    end else begin
      sub_bits = pre_q[1:0];
    end
  end

  assign tick = run & timer_on &
                (ps16 ? (pre16_q == 6'h3F) : (pre_q == pre_limit));
  // Postscaler bits play no part here
  assign boundary = tick & (tmr_q == period_q);
  assign time_base = {tmr_q, sub_bits};
  assign tmr_wr = wr_en && req.paddr == tbpw_pkg::ADDR_PERIOD_TIMER_COUNT;

  // Prescalers run while the timer is on and the unit is awake
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_q <= 4'h0;
      pre16_q <= 6'h00;
    end else if (tmr_wr || !timer_on) begin
      pre_q <= 4'h0;  // Writing the timer clears the prescaler
      pre16_q <= 6'h00;
    end else if (run) begin
      pre_q <= (pre_q == pre_limit) ? 4'h0 : pre_q + 4'h1;
      pre16_q <= pre16_q + 6'h01;
    end
  end

  // Period timer: clears on the step after matching
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tmr_q <= tbpw_pkg::RST_TIMER_COUNT;
    end else if (tmr_wr) begin
      tmr_q <= req.pwdata[7:0];
    end else if (boundary) begin
      tmr_q <= 8'h00;
    end else if (tick) begin
      tmr_q <= tmr_q + 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // Duty double buffer
  // ----------------------------------------------------------------
  logic [7:0] duty_buf_q;    // duty_buffer_high, read-only in PWM
  logic [1:0] duty_lat_q;    // Hidden 2-bit latch
  logic [9:0] duty_cmp;      // Buffered duty for comparison
  logic [9:0] duty_new;      // Duty that starts next period

  assign duty_new = {duty_byte_q,
                     ctl_q[tbpw_pkg::CTL_DUTY_LSB +: 2]};
  assign duty_cmp = {duty_buf_q, duty_lat_q};

  // In PWM mode load only at the boundary, so a mid-period write cannot glitch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      duty_buf_q <= tbpw_pkg::RST_DUTY;
      duty_lat_q <= 2'h0;
    end else if (boundary) begin
      duty_buf_q <= duty_new[9:2];
      duty_lat_q <= duty_new[1:0];
    end else if (!pwm_mode && wr_en &&
                 req.paddr == tbpw_pkg::ADDR_DUTY_BUFFER_HIGH) begin
      duty_buf_q <= req.pwdata[7:0];  // Writable outside PWM only
    end
  end

  // ----------------------------------------------------------------
  // Waveform
  // ----------------------------------------------------------------
  logic pwm_q;               // Raw PWM level, active high
  logic armed_q;             // A new period has begun since enable
  logic ovf_q;               // period_overflow_flag
  logic flag_clr;            // Software write of zero to the flag
  logic duty_hit;            // Time base sits at the buffered duty

  // Match drops the level in its own cycle, so width is duty time-base steps
  assign duty_hit = armed_q & (time_base == duty_cmp);

  // Arm only at a boundary: the first partial period stays quiet
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      armed_q <= 1'b0;
    end else if (!pwm_mode) begin
      armed_q <= 1'b0;
    end else if (boundary) begin
      armed_q <= 1'b1;
    end
  end

  // Set at period start, clear on duty match
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwm_q <= 1'b0;
    end else if (!pwm_mode) begin
      pwm_q <= 1'b0;  // Unit off holds the level low; the enable still follows dir_q
    end else if (boundary) begin
      pwm_q <= (duty_new != 10'h000);  // Zero duty: not set
    end else if (run && duty_hit) begin
      pwm_q <= 1'b0;  // Beyond period never matches
    end
  end

  // Overflow flag: set wins over a software clear in the same cycle
  assign flag_clr = wr_en && req.paddr == tbpw_pkg::ADDR_FLAG_REG &&
                    !req.pwdata[tbpw_pkg::FLAG_OVF_BIT];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovf_q <= 1'b0;
    end else if (boundary) begin
      ovf_q <= 1'b1;
    end else if (flag_clr) begin
      ovf_q <= 1'b0;
    end
  end
  assign period_overflow_flag = ovf_q;

  // Output mapping with per-pin polarity and bridge mode
  logic pri_lvl;             // Primary before polarity
  logic sec_lvl;             // Secondary before polarity
  logic sec_used;            // Secondary pin owned by the unit
  always_comb begin
    pri_lvl = pwm_q & ~duty_hit;  // Low from the match cycle
    sec_lvl = 1'b0;
    sec_used = 1'b0;
    if (emode == tbpw_pkg::EMODE_HALF_BRIDGE) begin
      sec_lvl = ~pri_lvl & armed_q;  // Complement
      sec_used = 1'b1;
    end
  end

  // Registered pin outputs; polarity from mode bits 1:0
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      primary_output <= 1'b0;
      secondary_output <= 1'b0;
    end else if (run) begin
      primary_output <= pwm_mode & (pri_lvl ^ mode_bits[1]);
      secondary_output <= pwm_mode & sec_used & (sec_lvl ^ mode_bits[0]);
    end
  end

  // Enables low while driving
  assign primary_oe_n = dir_q[tbpw_pkg::DIR_PRI_BIT];
  assign secondary_oe_n = dir_q[tbpw_pkg::DIR_SEC_BIT];

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  always_comb begin
    prdata = 32'h0000_0000;
    if (req.psel && req.penable && !req.pwrite) begin
      unique case (req.paddr)
        tbpw_pkg::ADDR_PWM_CONTROL: prdata[7:0] = ctl_q;
        tbpw_pkg::ADDR_DUTY_LOW_BYTE: prdata[7:0] = duty_byte_q;
        tbpw_pkg::ADDR_DUTY_BUFFER_HIGH: prdata[7:0] = duty_buf_q;
        tbpw_pkg::ADDR_PERIOD_TIMER_COUNT: prdata[7:0] = tmr_q;
        tbpw_pkg::ADDR_PERIOD_REG: prdata[7:0] = period_q;
        tbpw_pkg::ADDR_PERIOD_TIMER_CTRL: prdata[7:0] = tctl_q;
        tbpw_pkg::ADDR_FLAG_REG: prdata[tbpw_pkg::FLAG_OVF_BIT] = ovf_q;
        tbpw_pkg::ADDR_PIN_DIRECTION: prdata[1:0] = dir_q;
        default: prdata = 32'h0000_0000;
      endcase
    end
  end

endmodule

`default_nettype wire

// ---- testbench/tbpw_top_assertions.sv ----
// Checker for the PWM unit, bound to the top module's ports
`timescale 1ns/1ps
`default_nettype none
module tbpw_top_assertions (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic sleep,
  input wire logic primary_output,
  input wire logic primary_oe_n,
  input wire logic secondary_output,
  input wire logic secondary_oe_n,
  input wire logic period_overflow_flag
);
  // ------------------------------------------------------------
  // Helper decode of the bus phase
  // ------------------------------------------------------------
  logic acc; // Access phase
  logic mapped; // Aligned and inside the map
  logic dir_wr; // Direction register write
  logic flag_clr; // Flag write with bit cleared
  assign acc = psel && penable;
  assign mapped = (paddr[1:0] == 2'h0) && (paddr <= 8'h1C);
  assign dir_wr = acc && pwrite && paddr == tbpw_pkg::ADDR_PIN_DIRECTION;
  assign flag_clr = acc && pwrite && paddr == tbpw_pkg::ADDR_FLAG_REG
    && !pwdata[tbpw_pkg::FLAG_OVF_BIT];
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  property p_ready; acc |-> pready; endproperty
  a_ready: assert property (p_ready) else $error("pready low in access");
  property p_unmapped; acc && !mapped |-> pslverr && prdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped access not refused");
  property p_mapped; acc && mapped |-> !pslverr; endproperty
  a_mapped: assert property (p_mapped) else $error("mapped access refused");
  property p_upper; acc && !pwrite |-> prdata[31:8] == 24'h0; endproperty
  a_upper: assert property (p_upper)
    else $error("upper read bits not zero");
  property p_dir_rd;
    acc && !pwrite && paddr == tbpw_pkg::ADDR_PIN_DIRECTION
      |-> prdata[1:0] == {secondary_oe_n, primary_oe_n};
  endproperty
  a_dir_rd: assert property (p_dir_rd)
    else $error("direction readback differs from enables");
  property p_flag_rd;
    acc && !pwrite && paddr == tbpw_pkg::ADDR_FLAG_REG
      |-> prdata[1] == period_overflow_flag;
  endproperty
  a_flag_rd: assert property (p_flag_rd)
    else $error("flag readback differs from flag");
  property p_oe_rst; $rose(presetn) |-> primary_oe_n && secondary_oe_n;
  endproperty
  a_oe_rst: assert property (p_oe_rst)
    else $error("pins driven right after reset");
  // Enables move only through a direction write, never on their own
  property p_oe_chg;
    $changed({primary_oe_n, secondary_oe_n}) |-> $past(dir_wr);
  endproperty
  a_oe_chg: assert property (p_oe_chg)
    else $error("enable changed without write");
  property p_flag_clr; $fell(period_overflow_flag) |-> $past(flag_clr);
  endproperty
  a_flag_clr: assert property (p_flag_clr)
    else $error("flag cleared without write");
  // Sleep well past the synchroniser freezes both pins
  property p_sleep;
    sleep [*6] |-> $stable(primary_output) && $stable(secondary_output);
  endproperty
  a_sleep: assert property (p_sleep)
    else $error("outputs moved in sleep");
endmodule
bind tbpw_top tbpw_top_assertions u_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .sleep(sleep), .primary_output(primary_output),
  .primary_oe_n(primary_oe_n), .secondary_output(secondary_output),
  .secondary_oe_n(secondary_oe_n),
  .period_overflow_flag(period_overflow_flag));
`default_nettype wire

// ---- testbench/tbpw_load_model.sv ----
// Load on the two pins: pull-down when undriven, pulse measurement on the primary pin only
`timescale 1ns/1ps
`default_nettype none
module tbpw_load_model (
  input wire logic pclk,
  input wire logic primary_output,
  input wire logic primary_oe_n,
  input wire logic secondary_output,
  input wire logic secondary_oe_n,
  output logic pri_lvl,
  output logic sec_lvl,
  output logic [31:0] rises,
  output logic [31:0] per_c,
  output logic [31:0] hi_c
);
  logic prev = 1'h0; // Level at last edge
  logic [31:0] since = 32'h0; // Cycles since last rise
  logic [31:0] hi = 32'h0; // Cycles high so far
  // Pins float to the pull-down until the driver is on
  assign pri_lvl = primary_oe_n ? 1'h0 : primary_output;
  assign sec_lvl = secondary_oe_n ? 1'h0 : secondary_output;
  initial begin
    rises = 32'h0;
    per_c = 32'h0;
    hi_c = 32'h0;
  end
  // Rise to rise is the period, rise to fall the pulse width
  always @(posedge pclk) begin
    prev <= pri_lvl;
    if (pri_lvl && !prev) begin
      per_c <= since;
      since <= 32'h1;
      hi <= 32'h1;
      rises <= rises + 32'h1;
    end else begin
      since <= since + 32'h1;
      if (pri_lvl) begin
        hi <= hi + 32'h1;
      end else if (prev) begin
        hi_c <= hi;
      end
    end
  end
endmodule
`default_nettype wire

// ---- testbench/timer_based_pwm_unit_tb.sv ----
// Self-checking bench of the PWM unit
`timescale 1ns/1ps
`default_nettype none
module timer_based_pwm_unit_tb;
  typedef struct {
    logic [7:0] pr;
    logic [1:0] ps;
    logic [9:0] du;
    logic [31:0] per;
    logic [31:0] hi;
  } tbpw_row_t;
  // Period and width in pclk: (pr+1)*4*ps and duty*ps
  tbpw_row_t rows [4] = '{'{8'h00, 2'h0, 10'h002, 32'h4, 32'h2},
    '{8'h01, 2'h1, 10'h003, 32'h20, 32'h0C},
    '{8'h03, 2'h2, 10'h005, 32'h100, 32'h50},
    '{8'h00, 2'h3, 10'h001, 32'h40, 32'h10}};
  logic pclk, presetn, psel, penable, pwrite, sleep, rerr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdat, t0;
  logic pready, pslverr, po, poe, so, soe, ovf, pl, sl;
  logic [31:0] rises, per_c, hi_c;
  int failures, cmp_count, nh_p, nh_s, nx, i;
  tbpw_top dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .sleep(sleep),
    .primary_output(po), .primary_oe_n(poe), .secondary_output(so),
    .secondary_oe_n(soe), .period_overflow_flag(ovf));
  tbpw_load_model load (.pclk(pclk), .primary_output(po),
    .primary_oe_n(poe), .secondary_output(so), .secondary_oe_n(soe),
    .pri_lvl(pl), .sec_lvl(sl), .rises(rises), .per_c(per_c), .hi_c(hi_c));
  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic results;
    $display("failures=%0d comparisons=%0d", failures, cmp_count);
    if (failures == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    cmp_count++;
    if (s !== x) begin
      failures++;
      $display("unexpected at %0t: got %h want %h", $time, s, x);
    end
  endtask
  // One transfer; waits for pready at most 16 edges
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    for (k = 0; k < 16; k++) begin
      @(posedge pclk);
      if (pready === 1'h1) break;
    end
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    if (k == 16) begin
      failures++;
      results();
    end
  endtask
  // Stop, program, restart, wait for overflow, then drive pins
  task automatic cfg(input logic [7:0] pr, input logic [1:0] ps,
    input logic [9:0] du, input logic [7:0] ctl);
    int k;
    apb(1'h1, tbpw_pkg::ADDR_PERIOD_TIMER_CTRL, 32'h0);
    apb(1'h1, tbpw_pkg::ADDR_PERIOD_REG, {24'h0, pr});
    apb(1'h1, tbpw_pkg::ADDR_DUTY_LOW_BYTE, {24'h0, du[9:2]});
    apb(1'h1, tbpw_pkg::ADDR_PWM_CONTROL,
      {24'h0, ctl | {2'h0, du[1:0], 4'h0}});
    apb(1'h1, tbpw_pkg::ADDR_PERIOD_TIMER_COUNT, 32'h0);
    apb(1'h1, tbpw_pkg::ADDR_FLAG_REG, 32'h0);
    apb(1'h1, tbpw_pkg::ADDR_PERIOD_TIMER_CTRL, {29'h0, 1'h1, ps});
    for (k = 0; k < 400; k++) begin
      apb(1'h0, tbpw_pkg::ADDR_FLAG_REG, 32'h0);
      if (rdat[1] === 1'h1) break;
    end
    chk({31'h0, rdat[1]}, 32'h1);
    if (rdat[1] !== 1'h1) begin
      results();
    end
    apb(1'h1, tbpw_pkg::ADDR_PIN_DIRECTION, 32'h0);
  endtask
  task automatic wait_rises(input logic [31:0] n);
    int k;
    t0 = rises + n;
    for (k = 0; k < 4000 && rises < t0; k++) @(posedge pclk);
    if (rises < t0) begin
      failures++;
      results();
    end
  endtask
  // Counts high pins and cycles where the two pins agree
  task automatic sample(input int n);
    nh_p = 0;
    nh_s = 0;
    nx = 0;
    repeat (n) begin
      @(posedge pclk);
      nh_p += pl;
      nh_s += sl;
      nx += (pl == sl);
    end
  endtask
  // ------------------------------------------------------------
  // Clock and main sequence
  // ------------------------------------------------------------
  initial begin
    pclk = 1'h0;
    forever #12.5 pclk = ~pclk;
  end
  initial begin
    {presetn, psel, penable, pwrite, sleep} = 5'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    failures = 0;
    cmp_count = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    for (i = 0; i < 4; i++) begin
      cfg(rows[i].pr, rows[i].ps, rows[i].du, 8'h0C);
      wait_rises(32'h3);
      chk(per_c, rows[i].per);
      chk(hi_c, rows[i].hi);
    end
    // Duty past the period never clears; zero duty never sets
    cfg(8'h00, 2'h0, 10'h005, 8'h0C);
    sample(40);
    chk(nh_p, 32'h28);
    apb(1'h1, tbpw_pkg::ADDR_DUTY_BUFFER_HIGH, 32'hAA);
    apb(1'h0, tbpw_pkg::ADDR_DUTY_BUFFER_HIGH, 32'h0);
    chk(rdat, 32'h1);
    cfg(8'h00, 2'h0, 10'h000, 8'h0C);
    sample(40);
    chk(nh_p, 32'h0);
    chk(nh_s, 32'h0);
    // Half-bridge: complement, then both polarities inverted
    cfg(8'h00, 2'h0, 10'h002, 8'h8C);
    sample(40);
    chk(nx, 32'h0);
    cfg(8'h00, 2'h0, 10'h005, 8'h8F);
    sample(40);
    chk(nh_p, 32'h0);
    chk(nh_s, 32'h28);
    // Sleep freezes the timer, wake resumes it
    cfg(8'h40, 2'h0, 10'h010, 8'h0C);
    sleep <= 1'h1;
    repeat (4) @(posedge pclk);
    apb(1'h0, tbpw_pkg::ADDR_PERIOD_TIMER_COUNT, 32'h0);
    t0 = rdat;
    repeat (40) @(posedge pclk);
    apb(1'h0, tbpw_pkg::ADDR_PERIOD_TIMER_COUNT, 32'h0);
    chk(rdat, t0);
    sleep <= 1'h0;
    repeat (8) @(posedge pclk);
    apb(1'h0, tbpw_pkg::ADDR_PERIOD_TIMER_COUNT, 32'h0);
    chk({31'h0, rdat !== t0}, 32'h1);
    apb(1'h0, 8'h20, 32'h0);
    chk({31'h0, rerr}, 32'h1);
    // Reset in mid-run: pins released, registers back to defaults
    @(posedge pclk);
    presetn <= 1'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    chk({30'h0, soe, poe}, 32'h3);
    apb(1'h0, tbpw_pkg::ADDR_PWM_CONTROL, 32'h0);
    chk(rdat, 32'h0);
    apb(1'h0, tbpw_pkg::ADDR_PERIOD_TIMER_COUNT, 32'h0);
    chk(rdat, 32'h0);
    apb(1'h0, tbpw_pkg::ADDR_PIN_DIRECTION, 32'h0);
    chk(rdat, 32'h3);
    // Outside PWM mode the buffer byte takes writes
    apb(1'h1, tbpw_pkg::ADDR_DUTY_BUFFER_HIGH, 32'hAA);
    apb(1'h0, tbpw_pkg::ADDR_DUTY_BUFFER_HIGH, 32'h0);
    chk(rdat, 32'hAA);
    results();
  end
endmodule
`default_nettype wire
